// file: core/rpd_regs.svh
// Purpose: Register offsets, field layout and timing counts for the
//          regulator power-down order block.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes: Offsets 0x5f..0x65 are not all multiples of four, so they are
//        register indices; the byte address is four times the index.
`ifndef RPD_REGS_SVH
`define RPD_REGS_SVH

// Register indices, buck1 first, memory reference last output, then control and status
`define RPD_IDX_BUCK1 8'h5f
`define RPD_IDX_BUCK2 8'h60
`define RPD_IDX_BUCK3 8'h61
`define RPD_IDX_LINREG1 8'h62
`define RPD_IDX_LINREG2 8'h63
`define RPD_IDX_LINREG3 8'h64
`define RPD_IDX_MEMREF 8'h65
`define RPD_IDX_CTRL 8'h70
`define RPD_IDX_STATUS 8'h71

// Order field layout
`define RPD_ORDER_MSB 2
`define RPD_ORDER_LSB 0
`define RPD_ORDER_RESET 3'h0
`define RPD_ORDER_TOP 3'h7

// Control register bits
`define RPD_CTRL_START 0
`define RPD_CTRL_SYSON 1

// Inter-step delay
`define RPD_STEP_NS 1000
`define RPD_CLK_NS 25

`endif

// file: core/rpd_pkg.sv
// Purpose: Types for the regulator power-down order block.
// Assumes: Seven supply outputs.
// Notes: States are one-hot.
package rpd_pkg;
    typedef enum logic [3:0] {
        RPD_IDLE = 4'h1,
        RPD_STEP = 4'h2,
        RPD_WAIT = 4'h4,
        RPD_DONE = 4'h8
    } rpd_state_e;
    typedef logic [2:0] rpd_order_t;
endpackage

// file: core/rpd_step_timer.sv
// Purpose: Down counter timing the gap between shutdown steps.
// Assumes: load pulses for one cycle.
// Notes: expired is a level, high while the count is zero.
`timescale 1ns/1ps
module rpd_step_timer #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] COUNT = 8'h28
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    output logic expired
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
    } rpd_timer_s;
    rpd_timer_s cur;
    rpd_timer_s next_cur;

    // Reload on request, otherwise count down to zero and hold
    always_comb begin
        next_cur = cur;
        if (load) begin
            next_cur.cnt = COUNT;
        end else if (cur.cnt != '0) begin
            next_cur.cnt = cur.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign expired = (cur.cnt == '0);
endmodule

// file: core/rpd_sequencer.sv
// Purpose: Power-down order registers and shutdown sequencer on APB.
// Assumes: Outputs 0..6 are buck1..3, linreg1..3, memory reference.
// Notes: Orders of zero go off in the final step after order one.
`timescale 1ns/1ps
`include "rpd_regs.svh"
module rpd_sequencer #(
    parameter int NOUT = 7,
    parameter int STEP_CYCLES = `RPD_STEP_NS / `RPD_CLK_NS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cfg_load,
    input wire logic test_config_override,
    input wire logic [3*NOUT-1:0] fused_on_order,
    input wire logic [3*NOUT-1:0] test_on_order,
    output logic [3*NOUT-1:0] startup_order,
    output logic [NOUT-1:0] supply_en,
    output logic seq_busy
);
    localparam logic [7:0] STEP_CNT = 8'(STEP_CYCLES);

    typedef struct packed {
        rpd_pkg::rpd_state_e state;
        logic [3*NOUT-1:0] order;
        logic [NOUT-1:0] en;
        rpd_pkg::rpd_order_t level;
        logic syson;
        logic [31:0] rdata;
    } rpd_state_s;

    rpd_state_s cur;
    rpd_state_s next_cur;
    logic timer_load;
    logic timer_expired;
    logic wr;
    logic rd;
    logic [9:0] idx;
    logic all_zero;
    logic rd_order;
    logic [NOUT-1:0] step_mask;

    // Map a register index to an output number, NOUT when unmapped
    function automatic int rpd_out_of(input logic [9:0] i);
        int n;
        n = NOUT;
        for (int k = 0; k < NOUT; k++) begin
            if (i == 10'(`RPD_IDX_MEMREF) - 10'(NOUT - 1 - k)) begin
                n = k;
            end
        end
        return n;
    endfunction

    function automatic rpd_pkg::rpd_order_t rpd_field(
        input logic [3*NOUT-1:0] v, input int k);
        return v[3*k +: 3];
    endfunction

    // Outputs whose off order equals the given level
    function automatic logic [NOUT-1:0] rpd_match(
        input logic [3*NOUT-1:0] v, input rpd_pkg::rpd_order_t lv);
        logic [NOUT-1:0] m;
        m = '0;
        for (int k = 0; k < NOUT; k++) begin
            m[k] = (v[3*k +: 3] == lv);
        end
        return m;
    endfunction

    // Zero-wait APB: every access completes in its first access cycle
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign idx = paddr[11:2];
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // Shared decodes for the step logic and the checks
    assign rd_order = rd && (rpd_out_of(idx) < NOUT);
    assign step_mask = rpd_match(cur.order, cur.level);

    // Bypass check on the live fields
    always_comb begin
        all_zero = 1'b1;
        for (int k = 0; k < NOUT; k++) begin
            if (rpd_field(cur.order, k) != `RPD_ORDER_RESET) begin
                all_zero = 1'b0;
            end
        end
    end

    assign startup_order = test_config_override ? test_on_order
                                                : fused_on_order;

    // Register writes, read capture and the shutdown state machine
    always_comb begin
        int n;
        n = NOUT;
        next_cur = cur;
        timer_load = 1'b0;
        if (rd) begin
            n = rpd_out_of(idx);
            if (n < NOUT) begin
                next_cur.rdata = {29'h0, rpd_field(cur.order, n)};
            end else if (idx == 10'(`RPD_IDX_CTRL)) begin
                next_cur.rdata = {30'h0, cur.syson, 1'b0};
            end else if (idx == 10'(`RPD_IDX_STATUS)) begin
                next_cur.rdata = {21'h0, cur.level, cur.en,
                                  cur.state != rpd_pkg::RPD_IDLE};
            end else begin
                next_cur.rdata = 32'h0;
            end
        end
        if (cfg_load) begin
            next_cur.order = fused_on_order;
        end else if (wr && cur.syson) begin
            n = rpd_out_of(idx);
            if (n < NOUT) begin
                next_cur.order[3*n +: 3] =
                    pwdata[`RPD_ORDER_MSB:`RPD_ORDER_LSB];
            end
        end
        if (wr && idx == 10'(`RPD_IDX_CTRL)) begin
            next_cur.syson = pwdata[`RPD_CTRL_SYSON];
        end
        unique case (cur.state)
            rpd_pkg::RPD_IDLE: begin
                if (wr && idx == 10'(`RPD_IDX_CTRL)
                    && pwdata[`RPD_CTRL_START]) begin
                    next_cur.syson = 1'b0;
                    if (all_zero) begin
                        next_cur.en = '0;
                        next_cur.state = rpd_pkg::RPD_DONE;
                    end else begin
                        next_cur.level = `RPD_ORDER_TOP;
                        next_cur.state = rpd_pkg::RPD_STEP;
                    end
                end
            end
            rpd_pkg::RPD_STEP: begin
                next_cur.en = cur.en & ~step_mask;
                timer_load = 1'b1;
                next_cur.state = rpd_pkg::RPD_WAIT;
            end
            rpd_pkg::RPD_WAIT: begin
                if (timer_expired && !timer_load) begin
                    if (cur.level == `RPD_ORDER_RESET) begin
                        next_cur.state = rpd_pkg::RPD_DONE;
                    end else begin
                        next_cur.level = cur.level - 3'h1;
                        next_cur.state = rpd_pkg::RPD_STEP;
                    end
                end
            end
            rpd_pkg::RPD_DONE: begin
                // Re-arm by writing system-on; outputs back on
                if (next_cur.syson) begin
                    next_cur.en = '1;
                    next_cur.state = rpd_pkg::RPD_IDLE;
                end
            end
            default: begin
                next_cur.state = rpd_pkg::RPD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur.state <= rpd_pkg::RPD_IDLE;
            cur.order <= '0;
            cur.en <= '1;
            cur.level <= `RPD_ORDER_RESET;
            cur.syson <= 1'b1;
            cur.rdata <= 32'h0;
        end else begin
            cur <= next_cur;
        end
    end

    rpd_step_timer #(
        .WIDTH(8),
        .COUNT(STEP_CNT)
    ) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .load(timer_load),
        .expired(timer_expired)
    );

    assign prdata = cur.rdata;
    assign supply_en = cur.en;
    assign seq_busy = (cur.state != rpd_pkg::RPD_IDLE);

    // Checks
    property p_startup_src;
        @(posedge clk) disable iff (!rst_n)
        !test_config_override |-> startup_order == fused_on_order;
    endproperty
    a_startup_src: assert property (p_startup_src)
        else $error("startup order not from fuses");

    property p_cfg_mirror;
        @(posedge clk) disable iff (!rst_n)
        cfg_load |=> cur.order == $past(fused_on_order);
    endproperty
    a_cfg_mirror: assert property (p_cfg_mirror)
        else $error("off order not loaded from fuses");

    property p_bypass;
        @(posedge clk) disable iff (!rst_n)
        (cur.state == rpd_pkg::RPD_IDLE && wr && all_zero
         && idx == 10'(`RPD_IDX_CTRL) && pwdata[`RPD_CTRL_START])
        |=> supply_en == '0;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass did not switch all off");

    property p_write;
        @(posedge clk) disable iff (!rst_n)
        (wr && cur.syson && !cfg_load
         && idx == 10'(`RPD_IDX_BUCK3))
        |=> cur.order[8:6] == $past(pwdata[2:0]);
    endproperty
    a_write: assert property (p_write)
        else $error("order write lost");

    sequence s_step_done;
        cur.state == rpd_pkg::RPD_STEP ##1 cur.state == rpd_pkg::RPD_WAIT;
    endsequence
    property p_descend;
        @(posedge clk) disable iff (!rst_n)
        (cur.state == rpd_pkg::RPD_STEP && cur.level != 3'h0)
        |-> s_step_done ##[1:300] (cur.state == rpd_pkg::RPD_STEP
            && cur.level == $past(cur.level) - 3'h1);
    endproperty
    a_descend: assert property (p_descend)
        else $error("level did not descend");

    property p_gap;
        @(posedge clk) disable iff (!rst_n)
        s_step_done |-> cur.state == rpd_pkg::RPD_WAIT [*8];
    endproperty
    a_gap: assert property (p_gap)
        else $error("step gap too short");

    property p_field;
        @(posedge clk) disable iff (!rst_n)
        rd_order |=> prdata[31:3] == 29'h0;
    endproperty
    a_field: assert property (p_field)
        else $error("upper order bits not zero");

    property p_nowrite_off;
        @(posedge clk) disable iff (!rst_n)
        (!cur.syson && !cfg_load) |=> $stable(cur.order);
    endproperty
    a_nowrite_off: assert property (p_nowrite_off)
        else $error("order changed outside system-on");

    property p_no_early_on;
        @(posedge clk) disable iff (!rst_n)
        cur.state != rpd_pkg::RPD_DONE
        |=> (supply_en & ~$past(supply_en)) == '0;
    endproperty
    a_no_early_on: assert property (p_no_early_on)
        else $error("output switched on during shutdown");

    property p_step_off;
        @(posedge clk) disable iff (!rst_n)
        cur.state == rpd_pkg::RPD_STEP
        |=> (supply_en & $past(step_mask)) == '0;
    endproperty
    a_step_off: assert property (p_step_off)
        else $error("output of current level still on");

    property p_wait_hold;
        @(posedge clk) disable iff (!rst_n)
        cur.state == rpd_pkg::RPD_WAIT |=> $stable(supply_en);
    endproperty
    a_wait_hold: assert property (p_wait_hold)
        else $error("outputs changed during step gap");
endmodule

// file: verification/tb_top.sv
// Purpose: Self-checking bench for the power-down order sequencer.
// Assumes: Zero-wait APB slave; step delay shortened to 8 cycles.
// Notes: Byte address is four times the register index.
`timescale 1ns/1ps
`include "rpd_regs.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
    failures++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_top;
    localparam int STEP = 8;
    localparam logic [7:0] IDX0 = 8'h5f; // Index of buck1
    localparam logic [20:0] FUSED = {3'h3, 3'h7, 3'h0, 3'h1, 3'h5, 3'h5, 3'h3};
    localparam logic [20:0] TESTO = 21'h0a5a5a;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic cfg_load = 1'b0;
    logic test_config_override = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [20:0] startup_order;
    logic [6:0] supply_en;
    logic seq_busy;
    logic [31:0] rd;
    logic [2:0] ord [7];
    int failures = 0;
    int compares = 0;

    rpd_sequencer #(.NOUT(7), .STEP_CYCLES(STEP)) uut (.clk(clk),
        .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cfg_load(cfg_load),
        .test_config_override(test_config_override),
        .fused_on_order(FUSED), .test_on_order(TESTO),
        .startup_order(startup_order), .supply_en(supply_en),
        .seq_busy(seq_busy));

    // Free-running 40 MHz clock
    always #12.5 clk = ~clk;

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) failures++;
        `CHK("pslverr", 1'b0, pslverr)
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string nm, input logic [7:0] idx,
                         input logic [31:0] ex);
        apb(1'b0, idx, 32'h00000000);
        `CHK(nm, ex, rd)
    endtask

    // Waits for the next change of the enables, bounded
    task automatic wait_chg(output int gap);
        logic [6:0] prev;
        prev = supply_en;
        gap = 0;
        do begin
            @(posedge clk);
            #1;
            gap++;
        end while (supply_en === prev && gap < 500);
        if (gap >= 500) failures++;
    endtask

    // Starts a shutdown and follows each step that switches outputs off, from level 7 down to 0
    task automatic run_seq();
        logic [6:0] cur;
        logic [6:0] drop;
        int gap;
        logic first;
        cur = 7'h7f;
        first = 1'b1;
        apb(1'b1, `RPD_IDX_CTRL, 32'h00000001);
        for (int lv = 7; lv >= 0; lv--) begin
            drop = 7'h00;
            for (int k = 0; k < 7; k++)
                if (ord[k] == 3'(lv)) drop[k] = 1'b1;
            if (drop != 7'h00) begin
                wait_chg(gap);
                cur = cur & ~drop;
                `CHK("supply_en", cur, supply_en)
                if (!first) `CHK("gap", 1'b1, gap > STEP)
                first = 1'b0;
            end
        end
        `CHK("seq_busy", 1'b1, seq_busy)
    endtask

    // Let the remaining empty levels drain, then back to system-on
    task automatic restore();
        repeat (8 * (STEP + 2)) @(posedge clk);
        apb(1'b1, `RPD_IDX_CTRL, 32'h00000002);
        rdchk("status", `RPD_IDX_STATUS, 32'h000000fe);
        rdchk("ctrl", `RPD_IDX_CTRL, 32'h00000002);
        `CHK("supply_en", 7'h7f, supply_en)
        `CHK("seq_busy", 1'b0, seq_busy)
    endtask

    task automatic test_done();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog; a full run takes well under 3000 cycles
    initial begin
        #500000;
        failures++;
        test_done();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (int k = 0; k < 7; k++) rdchk("order", IDX0 + 8'(k), 0);
        `CHK("supply_en", 7'h7f, supply_en)
        `CHK("startup", FUSED, startup_order)
        test_config_override <= 1'b1;
        @(posedge clk);
        #1;
        `CHK("startup", TESTO, startup_order)
        @(posedge clk);
        test_config_override <= 1'b0;
        cfg_load <= 1'b1;
        @(posedge clk);
        cfg_load <= 1'b0;
        for (int k = 0; k < 7; k++) begin
            ord[k] = FUSED[3*k +: 3];
            rdchk("order", IDX0 + 8'(k), 32'(ord[k]));
        end
        run_seq();
        // Order writes are refused once system-on has cleared
        apb(1'b1, IDX0, 32'h00000006);
        rdchk("order", IDX0, 32'(ord[0]));
        restore();
        for (int k = 0; k < 7; k++) begin
            ord[k] = 3'(k + 1);
            apb(1'b1, IDX0 + 8'(k), 32'h000000f8 | 32'(k + 1));
            rdchk("order", IDX0 + 8'(k), 32'(k + 1));
        end
        `CHK("startup", FUSED, startup_order)
        run_seq();
        restore();
        for (int k = 0; k < 7; k++) begin
            ord[k] = 3'h0;
            apb(1'b1, IDX0 + 8'(k), 32'h00000000);
        end
        begin : all_off
            int gap;
            apb(1'b1, `RPD_IDX_CTRL, 32'h00000001);
            wait_chg(gap);
            `CHK("supply_en", 7'h00, supply_en)
            `CHK("gap", 1'b1, gap <= 2)
        end
        restore();
        apb(1'b1, 8'h50, 32'h00000007);
        rdchk("unmapped", 8'h50, 32'h00000000);
        test_done();
    end
endmodule
